/* File: bppp_pci_agent.sv */
// primary bus model: parking arbiter and a target that answers the bridge as master
`timescale 1ns/1ps
module bppp_pci_agent (
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       frame_n_in,
  input  wire logic       irdy_n_in,
  input  wire logic       bridge_mst_in,
  input  wire logic       req_n_in,
  input  wire logic       park_in,
  input  wire logic [3:0] lat_in,
  output logic            gnt_n_out,
  output logic            tgt_n_out,
  output logic            tgt_oe_out
);
  logic [1:0] st_r;
  logic [3:0] cnt_r;
  logic       fr_r;
  // one low line stands for both device select and target ready
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= 2'h0;
      cnt_r <= 4'h0;
      fr_r <= 1'b1;
      gnt_n_out <= 1'b1;
      tgt_n_out <= 1'b1;
      tgt_oe_out <= 1'b0;
    end else begin
      gnt_n_out <= !(park_in || !req_n_in);
      fr_r <= frame_n_in;
      case (st_r)
        2'h0: if (bridge_mst_in && !frame_n_in && fr_r) begin
          st_r <= 2'h1;
          cnt_r <= 4'h1;
        end
        2'h1: begin
          cnt_r <= cnt_r + 4'h1;
          // latency zero never claims, so the bridge must abort
          if (lat_in != 4'h0 && cnt_r == lat_in) begin
            tgt_n_out <= 1'b0;
            tgt_oe_out <= 1'b1;
            st_r <= 2'h2;
          end else if (frame_n_in && irdy_n_in) begin
            st_r <= 2'h0;
          end
        end
        2'h2: if (!irdy_n_in) begin
          tgt_n_out <= 1'b1;
          st_r <= 2'h3;
        end
        default: begin
          tgt_oe_out <= 1'b0;
          st_r <= 2'h0;
        end
      endcase
    end
  end
endmodule

/* File: bppp_pkg.sv */
// package for the primary pci port: pin groups, user groups, states and timing
package bppp_pkg;
  localparam logic [3:0] BPPP_DEVSEL_WAIT     = 4'h5;
  localparam logic [1:0] BPPP_REQ_GAP         = 2'h2;
  localparam logic [3:0] BPPP_CMD_CFG_RD      = 4'hA;
  localparam logic [3:0] BPPP_CMD_CFG_WR      = 4'hB;
  localparam logic [1:0] BPPP_CFG_TYPE0       = 2'h0;

  typedef enum logic [4:0] {
    BPPP_M_IDLE = 5'h01,
    BPPP_M_ADDR = 5'h02,
    BPPP_M_DATA = 5'h04,
    BPPP_M_TURN = 5'h08,
    BPPP_M_GAP  = 5'h10
  } bppp_mst_t;

  typedef enum logic [3:0] {
    BPPP_T_IDLE = 4'h1,
    BPPP_T_DATA = 4'h2,
    BPPP_T_TURN = 4'h4,
    BPPP_T_SKIP = 4'h8
  } bppp_tgt_t;

  // shared pci lines as seen from the pins
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  cbe_n;
    logic        par;
    logic        frame_n;
    logic        irdy_n;
    logic        trdy_n;
    logic        devsel_n;
    logic        stop_n;
  } bppp_pci_in_t;

  // one sustained tri-state output: level and enable
  typedef struct packed {
    logic val;
    logic oe;
  } bppp_sts_t;

  // request from the forwarding logic to run one single-word transfer
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [31:0] wdata;
    logic [3:0]  be_n;
    logic        posted;
  } bppp_mreq_t;

  typedef struct packed {
    logic        done;
    logic        master_abort;
    logic        target_abort;
    logic        retry;
    logic [31:0] rdata;
  } bppp_mrsp_t;

  // events from queues and secondary side that raise system error
  typedef struct packed {
    logic posted_discard;
    logic dly_wr_discard;
    logic dly_rd_discard;
    logic dly_master_timeout;
    logic posted_wr_perr_target;
  } bppp_serr_ev_t;
endpackage

/* File: bppp_primary_port.sv */
// primary pci port of the bridge: target and master handshakes, parity, error and arbitration
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - hold target ready until data phase ends
// - drive sustained outputs high one cycle first
// - master abort if no devsel in 5
// - assert device select on own decode
// - stop as target; obey stop as master
// - claim type 0 config only with select
// - parity error on bad received data
// - system error on parity, secondary, posted aborts
// - system error on discards and master timeout
// - system error drives only low, open drain
// - request bus when initiating
// - request stays off at least 2 clocks; after a drop of mreq_in.valid it can be off for only 1
// - start only with grant and idle bus
// - park ad, cbe, parity when granted idle
// - even parity, one clock after phase
// - frame marks start, release marks last
//////////////////////////////////////////////////////////////////////////////
module bppp_primary_port
  import bppp_pkg::*;
(
  input  wire logic                    core_clk_in,
  input  wire logic                    reset_n_in,
  input  wire bppp_pkg::bppp_pci_in_t  pci_in,
  input  wire logic                    primary_config_select_in,
  input  wire logic                    primary_grant_n_in,
  input  wire logic                    secondary_system_error_n_in,
  input  wire logic                    own_decode_in,
  input  wire logic                    tgt_stop_in,
  input  wire logic                    tgt_ready_in,
  input  wire logic [31:0]             tgt_rdata_in,
  input  wire bppp_pkg::bppp_mreq_t    mreq_in,
  input  wire bppp_pkg::bppp_serr_ev_t serr_ev_in,
  output logic [31:0]                  ad_out,
  output logic                         ad_oe_out,
  output logic [3:0]                   cbe_n_out,
  output logic                         cbe_oe_out,
  output logic                         par_out,
  output logic                         par_oe_out,
  output bppp_pkg::bppp_sts_t          frame_n_out,
  output bppp_pkg::bppp_sts_t          irdy_n_out,
  output bppp_pkg::bppp_sts_t          primary_target_ready_n_out,
  output bppp_pkg::bppp_sts_t          primary_device_select_n_out,
  output bppp_pkg::bppp_sts_t          stop_n_out,
  output bppp_pkg::bppp_sts_t          primary_parity_error_n_out,
  output logic                         primary_system_error_n_out,
  output logic                         primary_system_error_oe_out,
  output logic                         primary_request_n_out,
  output logic                         primary_request_oe_out,
  output logic                         tgt_start_out,
  output logic [31:0]                  tgt_addr_out,
  output logic [3:0]                   tgt_cmd_out,
  output logic                         tgt_wr_out,
  output logic [31:0]                  tgt_wdata_out,
  output logic                         mreq_ready_out,
  output bppp_pkg::bppp_mrsp_t         mrsp_out
);
  import bppp_pkg::*;

  typedef struct packed {
    bppp_mst_t   mst;
    bppp_tgt_t   tgt;
    logic [3:0]  dcnt;
    logic [1:0]  gap;
    logic        req_n;
    logic [31:0] ad;
    logic        ad_oe;
    logic [3:0]  cbe;
    logic        cbe_oe;
    logic        par;
    logic        par_oe;
    logic        chk_par;
    logic        chk_addr;
    logic        chk_posted;
    logic        lpar;
    bppp_sts_t   frame;
    bppp_sts_t   irdy;
    bppp_sts_t   trdy;
    bppp_sts_t   devsel;
    bppp_sts_t   stop;
    bppp_sts_t   perr;
    logic        serr;
    logic        tstart;
    logic [31:0] taddr;
    logic [3:0]  tcmd;
    logic        twr;
    logic [31:0] twdata;
    logic        rdvalid;
    bppp_mrsp_t  rsp;
  } bppp_state_t;

  bppp_state_t s_r;
  bppp_state_t s_nxt;
  logic        bus_idle;
  logic        claim;
  logic        par_calc;
  logic        posted_abort;
  logic        addr_perr;

  assign bus_idle = pci_in.frame_n & pci_in.irdy_n;
  assign par_calc = ^{pci_in.ad, pci_in.cbe_n};
  // type 0 config needs the select pin and type 1 config is never claimed; non-config decodes come from the forwarding logic
  assign claim = ((pci_in.cbe_n == BPPP_CMD_CFG_RD) || (pci_in.cbe_n == BPPP_CMD_CFG_WR))
               ? (primary_config_select_in && (pci_in.ad[1:0] == BPPP_CFG_TYPE0))
               : own_decode_in;
  // the done pulse makes an abort one event, not a level that lasts until the next transfer
  assign posted_abort = s_r.chk_posted && s_r.rsp.done && (s_r.rsp.master_abort || s_r.rsp.target_abort);
  // parity lags its ad and cbe by one clock, so it is held against last clock's bus
  assign addr_perr = s_r.chk_addr && (s_r.lpar != pci_in.par);

  always_comb begin
    s_nxt = s_r;
    s_nxt.tstart = 1'b0;
    s_nxt.rsp.done = 1'b0;
    s_nxt.chk_addr = 1'b0;
    s_nxt.chk_par = 1'b0;
    s_nxt.lpar = par_calc;
    // sustained outputs: an asserted one is parked high for one cycle (frame for the whole data phase and one cycle more), then released
    if (s_r.tgt == BPPP_T_TURN && s_r.devsel.oe && s_r.devsel.val) s_nxt.devsel.oe = 1'b0;
    if (s_r.tgt == BPPP_T_TURN && s_r.trdy.oe && s_r.trdy.val) s_nxt.trdy.oe = 1'b0;
    if (s_r.tgt == BPPP_T_TURN && s_r.stop.oe && s_r.stop.val) s_nxt.stop.oe = 1'b0;
    if (s_r.perr.oe && s_r.perr.val) s_nxt.perr.oe = 1'b0;
    if (s_r.perr.oe && !s_r.perr.val) s_nxt.perr.val = 1'b1;
    if (s_r.frame.oe && s_r.frame.val && s_r.mst == BPPP_M_TURN) s_nxt.frame.oe = 1'b0;
    if (s_r.irdy.oe && s_r.irdy.val && s_r.mst == BPPP_M_TURN) s_nxt.irdy.oe = 1'b0;
    // data parity on write data received as target
    if (s_r.chk_par && (s_r.lpar != pci_in.par)) begin
      s_nxt.perr = '{val: 1'b0, oe: 1'b1};
    end
    // read data parity as master goes one clock behind
    if (s_r.rdvalid && (s_r.lpar != pci_in.par)) s_nxt.perr = '{val: 1'b0, oe: 1'b1};
    s_nxt.rdvalid = 1'b0;
    // low for each clock with an event; a new event always wins over the release
    s_nxt.serr = addr_perr | !secondary_system_error_n_in | posted_abort
               | serr_ev_in.posted_wr_perr_target
               | serr_ev_in.posted_discard | serr_ev_in.dly_wr_discard
               | serr_ev_in.dly_rd_discard | serr_ev_in.dly_master_timeout;

    // target side
    case (s_r.tgt)
      BPPP_T_IDLE: begin
        if (!pci_in.frame_n && bus_idle == 1'b0 && s_r.mst == BPPP_M_IDLE && pci_in.irdy_n) begin
          s_nxt.chk_addr = 1'b1;
          if (claim) begin
            s_nxt.devsel = '{val: 1'b0, oe: 1'b1};
            s_nxt.trdy = '{val: 1'b1, oe: 1'b1};
            s_nxt.stop = '{val: 1'b1, oe: 1'b1};
            s_nxt.tstart = 1'b1;
            s_nxt.taddr = pci_in.ad;
            s_nxt.tcmd = pci_in.cbe_n;
            s_nxt.twr = pci_in.cbe_n[0];
            s_nxt.tgt = BPPP_T_DATA;
          end else begin
            s_nxt.tgt = BPPP_T_SKIP;
          end
        end
      end
      BPPP_T_DATA: begin
        if (tgt_stop_in && s_r.trdy.val) s_nxt.stop.val = 1'b0;
        if (tgt_ready_in && s_r.trdy.val) begin
          s_nxt.trdy.val = 1'b0;
          s_nxt.ad = tgt_rdata_in;
          s_nxt.ad_oe = !s_r.twr;
        end
        if (!s_r.ad_oe) s_nxt.par_oe = 1'b0;
        // once low, target ready holds until the initiator completes the phase
        if (!s_r.trdy.val && !pci_in.irdy_n) begin
          s_nxt.twdata = pci_in.ad;
          s_nxt.chk_par = s_r.twr;
          s_nxt.par = par_calc;
          s_nxt.par_oe = !s_r.twr;
          if (pci_in.frame_n) begin
            s_nxt.trdy.val = 1'b1;
            s_nxt.devsel.val = 1'b1;
            s_nxt.stop.val = 1'b1;
            s_nxt.ad_oe = 1'b0;
            s_nxt.tgt = BPPP_T_TURN;
          end
        end else if (!s_r.stop.val && pci_in.frame_n && !pci_in.irdy_n) begin
          s_nxt.devsel.val = 1'b1;
          s_nxt.stop.val = 1'b1;
          s_nxt.trdy.val = 1'b1;
          s_nxt.ad_oe = 1'b0;
          s_nxt.tgt = BPPP_T_TURN;
        end
      end
      BPPP_T_TURN: begin
        s_nxt.par_oe = 1'b0;
        s_nxt.tgt = BPPP_T_IDLE;
      end
      default: begin
        if (bus_idle) s_nxt.tgt = BPPP_T_IDLE;
      end
    endcase

    // master side
    case (s_r.mst)
      BPPP_M_IDLE: begin
        // once raised, the request holds until the start unless mreq_in.valid drops, so a busy target side never makes a short gap
        s_nxt.req_n = s_r.req_n ? !(mreq_in.valid && s_r.tgt == BPPP_T_IDLE) : !mreq_in.valid;
        if (!s_r.req_n && !primary_grant_n_in && bus_idle && s_r.tgt == BPPP_T_IDLE) begin
          s_nxt.frame = '{val: 1'b0, oe: 1'b1};
          s_nxt.irdy = '{val: 1'b1, oe: 1'b1};
          s_nxt.ad = mreq_in.addr;
          s_nxt.cbe = mreq_in.cmd;
          s_nxt.ad_oe = 1'b1;
          s_nxt.cbe_oe = 1'b1;
          s_nxt.chk_posted = mreq_in.posted;
          s_nxt.dcnt = '0;
          s_nxt.req_n = 1'b1;
          s_nxt.mst = BPPP_M_ADDR;
        end else if (!primary_grant_n_in && bus_idle && s_r.tgt == BPPP_T_IDLE) begin
          s_nxt.ad_oe = 1'b1;
          s_nxt.cbe_oe = 1'b1;
          s_nxt.par_oe = s_r.ad_oe;
          s_nxt.par = ^{s_r.ad, s_r.cbe};
        end else if (s_r.tgt == BPPP_T_IDLE) begin
          s_nxt.ad_oe = 1'b0;
          s_nxt.cbe_oe = 1'b0;
          s_nxt.par_oe = s_r.ad_oe & s_r.cbe_oe;
        end
      end
      BPPP_M_ADDR: begin
        s_nxt.par = ^{s_r.ad, s_r.cbe};
        s_nxt.par_oe = 1'b1;
        s_nxt.frame.val = 1'b1;                                       // single data phase
        s_nxt.irdy.val = 1'b0;
        s_nxt.cbe = mreq_in.be_n;
        s_nxt.ad = mreq_in.wdata;
        s_nxt.ad_oe = mreq_in.cmd[0];
        s_nxt.mst = BPPP_M_DATA;
      end
      BPPP_M_DATA: begin
        s_nxt.dcnt = s_r.dcnt + 4'h1;
        s_nxt.par = ^{s_r.ad, s_r.cbe};
        s_nxt.par_oe = s_r.ad_oe;
        s_nxt.rsp.master_abort = 1'b0;
        s_nxt.rsp.target_abort = 1'b0;
        s_nxt.rsp.retry = 1'b0;
        if (pci_in.devsel_n && s_r.dcnt >= BPPP_DEVSEL_WAIT - 4'h1) begin
          s_nxt.rsp.master_abort = 1'b1;
          s_nxt.mst = BPPP_M_TURN;
        end else if (!pci_in.trdy_n) begin
          s_nxt.rsp.rdata = pci_in.ad;
          s_nxt.rdvalid = !s_r.ad_oe;
          s_nxt.mst = BPPP_M_TURN;
        end else if (!pci_in.stop_n) begin
          s_nxt.rsp.target_abort = pci_in.devsel_n;
          s_nxt.rsp.retry = !pci_in.devsel_n;
          s_nxt.mst = BPPP_M_TURN;
        end
        if (s_nxt.mst == BPPP_M_TURN) begin
          s_nxt.irdy.val = 1'b1;
          s_nxt.ad_oe = 1'b0;
          s_nxt.cbe_oe = 1'b0;
          s_nxt.rsp.done = 1'b1;
        end
      end
      BPPP_M_TURN: begin
        s_nxt.par_oe = 1'b0;
        s_nxt.mst = BPPP_M_GAP;
      end
      default: begin
        s_nxt.gap = s_r.gap + 2'h1;
        if (s_r.gap == BPPP_REQ_GAP - 2'h1) begin
          s_nxt.gap = '0;
          s_nxt.mst = BPPP_M_IDLE;
        end
      end
    endcase
  end

  // the asynchronous reset alone tri-states every pin
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
      s_r.mst <= BPPP_M_IDLE;
      s_r.tgt <= BPPP_T_IDLE;
      s_r.req_n <= 1'b1;
      s_r.frame <= '{val: 1'b1, oe: 1'b0};
      s_r.irdy <= '{val: 1'b1, oe: 1'b0};
      s_r.trdy <= '{val: 1'b1, oe: 1'b0};
      s_r.devsel <= '{val: 1'b1, oe: 1'b0};
      s_r.stop <= '{val: 1'b1, oe: 1'b0};
      s_r.perr <= '{val: 1'b1, oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ad_out = s_r.ad;
  assign ad_oe_out = s_r.ad_oe;
  assign cbe_n_out = s_r.cbe;
  assign cbe_oe_out = s_r.cbe_oe;
  assign par_out = s_r.par;
  assign par_oe_out = s_r.par_oe;
  assign frame_n_out = s_r.frame;
  assign irdy_n_out = s_r.irdy;
  assign primary_target_ready_n_out = s_r.trdy;
  assign primary_device_select_n_out = s_r.devsel;
  assign stop_n_out = s_r.stop;
  assign primary_parity_error_n_out = s_r.perr;
  assign primary_system_error_n_out = 1'b0;
  assign primary_system_error_oe_out = s_r.serr;
  assign primary_request_n_out = s_r.req_n;
  assign primary_request_oe_out = reset_n_in;
  assign tgt_start_out = s_r.tstart;
  assign tgt_addr_out = s_r.taddr;
  assign tgt_cmd_out = s_r.tcmd;
  assign tgt_wr_out = s_r.twr;
  assign tgt_wdata_out = s_r.twdata;
  assign mreq_ready_out = s_r.rsp.done;
  assign mrsp_out = s_r.rsp;

  //////////////////////////////////////////////////////////////////////////////
  property primary_target_ready_n_hold;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (!s_r.trdy.val && s_r.trdy.oe && pci_in.irdy_n) |=> !s_r.trdy.val;
  endproperty
  a_trdy_hold: assert property (primary_target_ready_n_hold) else $error("target ready dropped mid phase");

  sequence s_devsel_high;
    s_r.devsel.oe && s_r.devsel.val;
  endsequence
  property primary_device_select_n_release;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      ($fell(s_r.devsel.oe)) |-> $past(s_r.devsel.val);
  endproperty
  a_devsel_release: assert property (primary_device_select_n_release) else $error("devsel released while low");

  property primary_device_select_n_park;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (s_r.tgt == BPPP_T_TURN) |-> s_devsel_high;
  endproperty
  a_devsel_park: assert property (primary_device_select_n_park) else $error("devsel not driven high before release");

  property p_mabort;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (s_r.mst == BPPP_M_DATA && s_r.dcnt == BPPP_DEVSEL_WAIT - 4'h1 && pci_in.devsel_n && pci_in.trdy_n)
        |=> s_r.rsp.master_abort;
  endproperty
  a_mabort: assert property (p_mabort) else $error("no master abort after devsel timeout");

  property p_req_gap;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      $rose(s_r.req_n) |=> s_r.req_n [*2];
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("request reasserted too soon");

  property p_start_grant;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      $fell(s_r.frame.val) |-> !$past(primary_grant_n_in) && $past(bus_idle);
  endproperty
  a_start_grant: assert property (p_start_grant) else $error("frame started without grant");

  property primary_system_error_n_od;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (secondary_system_error_n_in && !addr_perr && !posted_abort && serr_ev_in == '0)
        |=> !primary_system_error_oe_out;
  endproperty
  a_serr_od: assert property (primary_system_error_n_od) else $error("system error pulse stuck");

  property p_park;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (s_r.mst == BPPP_M_IDLE && s_r.req_n && !primary_grant_n_in && bus_idle && s_r.tgt == BPPP_T_IDLE)
        |=> (s_r.ad_oe && s_r.cbe_oe);
  endproperty
  a_park: assert property (p_park) else $error("bus not parked while granted");

  property primary_system_error_n_sec;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (!secondary_system_error_n_in && !s_r.serr) |=> s_r.serr;
  endproperty
  a_serr_sec: assert property (primary_system_error_n_sec) else $error("secondary error not forwarded");

  property p_cfg_claim;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (s_r.tstart && s_r.tcmd[3:1] == 3'h5) |-> $past(primary_config_select_in);
  endproperty
  a_cfg_claim: assert property (p_cfg_claim) else $error("config claimed without select");
endmodule

/* File: tb_bridge_primary_pci_port.sv */
// testbench of the primary pci port: target cycles, master cycles, errors, parking, reset
`timescale 1ns/1ps
module tb_bridge_primary_pci_port;
  import bppp_pkg::*;
  logic clk = 0, rst_n = 0, sel = 0, dec = 0, tstp = 0, trdy_in = 0, sec_n = 1, park = 0;
  logic tm = 0, tfr = 1, tir = 1, tpar = 0, tbad = 0;
  logic [31:0] tad = 0, alt = 32'h5A5A_5A5A, ad_o, pad;
  logic [3:0] tcbe = 0, lat = 0, cbe_o, pcbe;
  logic ad_oe, cbe_oe, par_o, par_oe, serr_n, serr_oe, rq_n, rq_oe, mrdy, gnt_n, ag_n, ag_oe;
  logic pad_oe, pfr = 1, pg = 1, perr_seen = 0, serr_seen = 0, req_seen = 0;
  bppp_sts_t fo, io, to, dso, so, po;
  logic tst, twr_o;
  logic [31:0] taddr_o, twd_o;
  logic [3:0] tcmd_o;
  bppp_mreq_t mreq = '0;
  bppp_mrsp_t mrsp;
  bppp_serr_ev_t sev = '0;
  bppp_pci_in_t pin;
  int fail_count = 0, n_checks = 0, cyc = 0, gap = 0;
  // undriven ad toggles so a stale value never looks valid
  wire [31:0] ad_w = ad_oe ? ad_o : (tm ? tad : alt);
  wire [3:0] cbe_w = cbe_oe ? cbe_o : (tm ? tcbe : alt[3:0]);
  wire par_w = par_oe ? par_o : (tm ? tpar : alt[0]);
  wire fr_w = fo.oe ? fo.val : (tm ? tfr : 1'b1);
  wire ir_w = io.oe ? io.val : (tm ? tir : 1'b1);
  wire tr_w = to.oe ? to.val : (ag_oe ? ag_n : 1'b1);
  wire dv_w = dso.oe ? dso.val : (ag_oe ? ag_n : 1'b1);
  wire st_w = so.oe ? so.val : 1'b1;
  assign pin = '{ad: ad_w, cbe_n: cbe_w, par: par_w, frame_n: fr_w, irdy_n: ir_w,
                 trdy_n: tr_w, devsel_n: dv_w, stop_n: st_w};
  initial begin
    forever #4 clk = ~clk;
  end
  bppp_primary_port bppp_primary_port_i (.core_clk_in(clk), .reset_n_in(rst_n), .pci_in(pin),
    .primary_config_select_in(sel), .primary_grant_n_in(gnt_n), .secondary_system_error_n_in(sec_n),
    .own_decode_in(dec), .tgt_stop_in(tstp), .tgt_ready_in(trdy_in), .tgt_rdata_in(32'h0000_0000),
    .mreq_in(mreq), .serr_ev_in(sev), .ad_out(ad_o), .ad_oe_out(ad_oe), .cbe_n_out(cbe_o),
    .cbe_oe_out(cbe_oe), .par_out(par_o), .par_oe_out(par_oe), .frame_n_out(fo), .irdy_n_out(io),
    .primary_target_ready_n_out(to), .primary_device_select_n_out(dso), .stop_n_out(so),
    .primary_parity_error_n_out(po), .primary_system_error_n_out(serr_n),
    .primary_system_error_oe_out(serr_oe), .primary_request_n_out(rq_n), .primary_request_oe_out(rq_oe),
    .tgt_start_out(tst), .tgt_addr_out(taddr_o), .tgt_cmd_out(tcmd_o), .tgt_wr_out(twr_o),
    .tgt_wdata_out(twd_o),
    .mreq_ready_out(mrdy), .mrsp_out(mrsp));
  bppp_pci_agent bppp_pci_agent_i (.core_clk_in(clk), .reset_n_in(rst_n), .frame_n_in(fr_w),
    .irdy_n_in(ir_w), .bridge_mst_in(fo.oe), .req_n_in(rq_oe ? rq_n : 1'b1), .park_in(park),
    .lat_in(lat), .gnt_n_out(gnt_n), .tgt_n_out(ag_n), .tgt_oe_out(ag_oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // parity for the initiator side lags its ad and cbe by one clock
  always @(negedge clk) tpar <= ^{tad, tcbe} ^ tbad;
  always @(negedge clk) alt <= ~alt;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
    pfr <= fr_w;
    pg <= gnt_n;
    pad <= ad_o;
    pcbe <= cbe_w;
    pad_oe <= ad_oe;
    if (po.oe && !po.val) perr_seen <= 1'b1;
    if (!rq_n && rq_oe) req_seen <= 1'b1;
    if (serr_oe) serr_seen <= 1'b1;
    if (serr_oe) check(serr_n, 1'b0, "system error driven high");
    if (rst_n && par_oe && pad_oe) check(^{pad, pcbe, par_o}, 1'b0, "odd parity");
    if (fo.oe && !fo.val && pfr) check(pg, 1'b0, "frame without grant");
    if (!rq_n && rq_oe && gap != 0) check(32'(gap >= 2), 1, "request gap short");
    gap <= (rq_n || !rq_oe) ? gap + 1 : 0;
  end
  task automatic tgt_cycle(input logic [3:0] cmd, input logic [31:0] a, input logic s, d, stp, bad, claim);
    int n;
    @(negedge clk);
    perr_seen = 0;
    tm <= 1; tfr <= 0; tad <= a; tcbe <= cmd; sel <= s; dec <= d; tstp <= stp;
    @(negedge clk);
    tfr <= 0 ^ 1; tad <= 32'h1357_9BDF; tcbe <= 4'h0; tbad <= bad; sel <= 0; dec <= 0;
    check(tst, claim, "target start");
    if (claim) check(taddr_o, a, "target address");
    if (claim) check({tcmd_o, twr_o}, {cmd, cmd[0]}, "target command");
    @(negedge clk);
    check(dv_w, !claim, "device select claim");
    if (claim) begin
      trdy_in <= !stp;
      n = 0;
      while (tr_w !== 1'b0 && st_w !== 1'b0 && n < 8) begin
        @(negedge clk);
        n++;
      end
      check(st_w, !stp, "stop level");
      // initiator holds off to see target ready stand
      repeat (2) begin
        @(negedge clk);
        if (!stp) check(tr_w, 1'b0, "target ready dropped");
      end
      tir <= 0;
      @(negedge clk);
      tir <= 1; trdy_in <= 0; tstp <= 0;
      check({to, dso}, 4'hF, "not driven high before release");
      check(so, 2'h3, "stop not driven high before release");
      if (!stp) check(twd_o, 32'h1357_9BDF, "target write data");
      @(negedge clk);
      check({to.oe, dso.oe, so.oe}, 3'h0, "not released");
    end
    tm <= 0; tbad <= 0;
    repeat (3) @(negedge clk);
    check(perr_seen, bad, "parity error report");
    $display("target cycle test done");
  endtask
  task automatic mst_xfer(input logic [3:0] l, input logic posted, input logic ma);
    int n;
    @(negedge clk);
    serr_seen = 0;
    req_seen = 0;
    lat <= l;
    mreq <= '{valid: 1, addr: 32'h0000_1000, cmd: 4'h7, wdata: 32'hCAFE_0001, be_n: 4'h0, posted: posted};
    n = 0;
    while (mrdy !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(mrdy, 1'b1, "master never done");
    check(mrsp.master_abort, ma, "master abort");
    check({mrsp.target_abort, mrsp.retry}, 2'h0, "unexpected stop response");
    check(req_seen, 1'b1, "no request");
    mreq.valid <= 0;
    repeat (3) @(negedge clk);
    check(serr_seen, ma & posted, "abort system error");
    $display("master test done");
  endtask
  task automatic serr_all();
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      serr_seen = 0;
      if (i < 5) sev <= 5'(1 << i);
      else sec_n <= 0;
      @(negedge clk);
      sev <= '0;
      sec_n <= 1;
      repeat (3) @(negedge clk);
      check(serr_seen, 1'b1, "event lost");
    end
    $display("system error test done");
  endtask
  task automatic park_reset();
    @(negedge clk);
    park <= 1;
    repeat (4) @(negedge clk);
    check({ad_oe, cbe_oe, par_oe}, 3'h7, "not parked");
    #2 rst_n <= 0;
    #1 check({ad_oe, cbe_oe, par_oe, fo.oe, io.oe, to.oe, dso.oe, so.oe, po.oe, serr_oe, rq_oe}, 0,
             "outputs driven in reset");
    park <= 0;
    @(negedge clk);
    rst_n <= 1;
    repeat (3) @(negedge clk);
    $display("park and reset test done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n <= 1;
    tgt_cycle(4'h7, 32'h0000_2000, 0, 1, 0, 0, 1);
    tgt_cycle(4'h7, 32'h0000_2000, 0, 0, 0, 0, 0);
    tgt_cycle(BPPP_CMD_CFG_WR, 32'h0000_0010, 0, 0, 0, 0, 0);
    tgt_cycle(BPPP_CMD_CFG_WR, 32'h0000_0010, 1, 0, 0, 1, 1);
    tgt_cycle(4'h7, 32'h0000_2000, 0, 1, 1, 0, 1);
    mst_xfer(4'h3, 1, 0);
    mst_xfer(4'h0, 1, 1);
    mst_xfer(4'h0, 0, 1);
    serr_all();
    park_reset();
    mst_xfer(4'h2, 0, 0);
    test_done();
  end
endmodule
